// ---- design/irw_resizer_window.sv ----
// Resizer channel window configuration registers and window sequencer
`timescale 1ns/1ps

// Operation
// R1 - Resizer runs only while enable bit 0 is one; zero disables it.
// R2 - Mode bit 0 selects continuous when zero, one-shot when one.
// R3 - Input first line picks the first processed line after origin.
// R4 - Input line count equals the field value plus one.
// R5 - Input line count applies only in input-line termination mode.
// R6 - Input first pixel picks the first processed pixel after origin.
// R7 - Input first pixel bit 0 is forced low; software writes even values.
// R8 - Output line count equals the field value plus one.
// R9 - Output line count bit 0 is forced high; software writes odd values.
// R10 - Leading resized pixels given by skip are dropped per line.
// R11 - Output pixel skip bit 0 is forced low; software writes even values.
// R12 - Output pixels per line equal the width field plus one.
// R13 - First channel width must stay below 1344 except raw passthrough.
// R14 - Second channel width must stay below 640.
// R15 - Output width bit 0 is forced high; software writes odd values.
// R16 - Fourteen-bit vertical phase loads the starting phase, 0 to 16383.
// R17 - Software keeps vertical phase zero outside split frame mode.
// R18 - Input-line termination runs until input lines used; reports lines made.
// R19 - Reserved bits read zero and ignore writes.
module irw_resizer_window (
  input wire logic clk, // 200 MHz clock
  input wire logic reset, // Synchronous active high reset
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lane selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  input wire logic frame_start, // Pulse at pipeline vertical origin
  input wire logic line_start, // Pulse before each input line
  input wire logic pix_valid, // Input pixel strobe
  input wire logic [15:0] pix_data, // Input pixel
  output logic out_valid, // Output pixel strobe
  output logic [15:0] out_data, // Output pixel
  output logic out_line_start, // First pixel of an output line
  output logic frame_done, // Pulse when a frame ends
  output logic [13:0] phase_start, // Phase loaded at frame start
  output logic busy // Sequencer inside a frame
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic enable_r;
  logic single_r;
  logic term_r;
  logic [11:0] i_line_r;
  logic [11:0] i_count_r;
  logic [11:0] i_pixel_r;
  logic [11:0] o_count_r;
  logic [11:0] o_skip_r;
  logic [11:0] o_width_r;
  logic [13:0] v_phase_r;
  logic [12:0] lines_done_r;
  irw_pkg::irw_state_t state_r;
  irw_pkg::irw_state_t state_nxt;
  logic [12:0] seen_r;
  logic [12:0] in_used_r;
  logic [12:0] out_lines_r;
  logic [12:0] pix_r;
  logic line_on_r;
  logic first_out_r;
  logic req;
  logic wr_en;
  logic lo_en;
  logic end_frame;
  logic target_hit;
  logic new_line;
  logic [12:0] ridx;
  logic [12:0] oidx;
  logic emit;
  logic [12:0] line_goal;
  logic [12:0] line_used;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Twelve-bit field write with bit 0 taken from b0
  function automatic logic [11:0] fld_wr(input logic [31:0] d, input logic b0);
    fld_wr = {d[11:1], b0};
  endfunction : fld_wr

  // Field value plus one at counter width
  function automatic logic [12:0] plus1(input logic [11:0] v);
    plus1 = {1'b0, v} + 13'h0001;
  endfunction : plus1

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  // New request seen only when ack is not already up; a write lands at the
  // request edge, one edge before ack, which a classic master cannot tell apart
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_en = req && wb_we_i;
  assign lo_en = wr_en && wb_sel_i[0];

  // Ack one cycle after the request, dropped the next cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req;
    end
  end

  // Read data; unmapped addresses and reserved bits read zero
  // Status bit 0 mirrors busy; lines produced is read only
  always_ff @(posedge clk) begin
    if (reset) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req) begin
      case (wb_adr_i)
        irw_pkg::OFF_ENABLE: wb_dat_o <= {31'h0, enable_r}; // R19
        irw_pkg::OFF_SINGLE: wb_dat_o <= {31'h0, single_r};
        irw_pkg::OFF_SEQ: wb_dat_o <= {30'h0, term_r, 1'b0};
        irw_pkg::OFF_I_LINE: wb_dat_o <= {20'h0, i_line_r};
        irw_pkg::OFF_I_COUNT: wb_dat_o <= {20'h0, i_count_r};
        irw_pkg::OFF_I_PIXEL: wb_dat_o <= {20'h0, i_pixel_r};
        irw_pkg::OFF_O_COUNT: wb_dat_o <= {20'h0, o_count_r};
        irw_pkg::OFF_O_SKIP: wb_dat_o <= {20'h0, o_skip_r};
        irw_pkg::OFF_O_WIDTH: wb_dat_o <= {20'h0, o_width_r};
        irw_pkg::OFF_V_PHASE: wb_dat_o <= {18'h0, v_phase_r};
        irw_pkg::OFF_LINES_DONE: wb_dat_o <= {19'h0, lines_done_r}; // R18
        irw_pkg::OFF_STATUS: wb_dat_o <= {31'h0, busy};
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Control registers
  // ----------------------------------------
  // Enable; one-shot clears it at frame end, a software write wins
  always_ff @(posedge clk) begin
    if (reset) begin
      enable_r <= irw_pkg::RST_ENABLE;
    end else if (lo_en && wb_adr_i == irw_pkg::OFF_ENABLE) begin
      enable_r <= wb_dat_i[irw_pkg::ENABLE_BIT]; // R1
    end else if (end_frame && single_r) begin
      enable_r <= 1'b0; // R2
    end
  end

  // Mode and termination select
  always_ff @(posedge clk) begin
    if (reset) begin
      single_r <= irw_pkg::RST_SINGLE;
      term_r <= irw_pkg::RST_TERM;
    end else begin
      if (lo_en && wb_adr_i == irw_pkg::OFF_SINGLE) begin
        single_r <= wb_dat_i[irw_pkg::SINGLE_BIT]; // R2
      end
      if (lo_en && wb_adr_i == irw_pkg::OFF_SEQ) begin
        term_r <= wb_dat_i[irw_pkg::TERM_BIT]; // R5
      end
    end
  end

  // Window fields; a write needs both low byte lanes and writes the whole field
  // Pixel start and skip keep bit 0 low, output sizes keep it high; input line fields take bit 0 as written
  always_ff @(posedge clk) begin
    if (reset) begin
      i_line_r <= irw_pkg::RST_FLD;
      i_count_r <= irw_pkg::RST_FLD;
      i_pixel_r <= irw_pkg::RST_FLD;
      o_count_r <= irw_pkg::RST_ODD_FLD;
      o_skip_r <= irw_pkg::RST_FLD;
      o_width_r <= irw_pkg::RST_ODD_FLD;
      v_phase_r <= irw_pkg::RST_PHASE;
    end else if (wr_en && wb_sel_i[1:0] == 2'h3) begin
      case (wb_adr_i)
        irw_pkg::OFF_I_LINE: i_line_r <= fld_wr(wb_dat_i, wb_dat_i[0]); // R3
        irw_pkg::OFF_I_COUNT: i_count_r <= fld_wr(wb_dat_i, wb_dat_i[0]); // R4
        irw_pkg::OFF_I_PIXEL: i_pixel_r <= fld_wr(wb_dat_i, 1'b0); // R7
        irw_pkg::OFF_O_COUNT: o_count_r <= fld_wr(wb_dat_i, 1'b1); // R9
        irw_pkg::OFF_O_SKIP: o_skip_r <= fld_wr(wb_dat_i, 1'b0); // R11
        irw_pkg::OFF_O_WIDTH: o_width_r <= fld_wr(wb_dat_i, 1'b1); // R15
        irw_pkg::OFF_V_PHASE: v_phase_r <= wb_dat_i[13:0]; // R16
        default: v_phase_r <= v_phase_r;
      endcase
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Goal and count of the selected termination mode
  assign line_goal = term_r ? plus1(i_count_r) : plus1(o_count_r); // R4 R5 R8
  assign line_used = term_r ? in_used_r : out_lines_r; // R5 R18
  assign target_hit = (line_used >= line_goal);

  // A window line opens at or after the first line until the target
  assign new_line = line_start && (seen_r >= {1'b0, i_line_r}) && !target_hit; // R3
  // A frame ends at the first line start past the target, so the last window line
  // keeps its pixels; a new frame start ends it as well. A source that stops
  // sending lines leaves the frame running until the next frame start.
  assign end_frame = (state_r == irw_pkg::ST_RUN)
    && ((line_start && target_hit) || frame_start); // R18

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      irw_pkg::ST_IDLE: begin
        if (enable_r) begin
          state_nxt = irw_pkg::ST_WAIT;
        end
      end
      irw_pkg::ST_WAIT: begin
        if (frame_start) begin
          state_nxt = irw_pkg::ST_RUN;
        end
      end
      irw_pkg::ST_RUN: begin
        if (end_frame) begin
          state_nxt = single_r ? irw_pkg::ST_IDLE : irw_pkg::ST_WAIT; // R2
        end
      end
      default: state_nxt = irw_pkg::ST_IDLE;
    endcase
    if (!enable_r) begin
      state_nxt = irw_pkg::ST_IDLE; // R1
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= irw_pkg::ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Busy while a frame runs; also the status bit
  assign busy = (state_r == irw_pkg::ST_RUN);

  // ----------------------------------------
  // Line counters
  // ----------------------------------------
  // Input line index since the frame start
  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      seen_r <= irw_pkg::RST_CNT;
    end else if (line_start) begin
      seen_r <= seen_r + 13'h0001;
    end
  end

  // Input lines taken into the window
  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      in_used_r <= irw_pkg::RST_CNT;
    end else if (new_line) begin
      in_used_r <= in_used_r + 13'h0001; // R18
    end
  end

  // Output lines made, one per window line at unit ratio
  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      out_lines_r <= irw_pkg::RST_CNT;
    end else if (new_line) begin
      out_lines_r <= out_lines_r + 13'h0001; // R8
    end
  end

  // Window line flag, held to the next line start so the last line keeps its pixels
  always_ff @(posedge clk) begin
    if (reset || !busy) begin
      line_on_r <= 1'b0;
    end else if (line_start) begin
      line_on_r <= new_line; // R3
    end
  end

  // Lines produced, latched when a frame ends
  always_ff @(posedge clk) begin
    if (reset) begin
      lines_done_r <= irw_pkg::RST_CNT;
    end else if (end_frame) begin
      lines_done_r <= out_lines_r; // R18
    end
  end

  // Initial vertical phase taken at frame start
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_start <= irw_pkg::RST_PHASE;
    end else if (state_r == irw_pkg::ST_WAIT && frame_start) begin
      phase_start <= v_phase_r; // R16
    end
  end

  // ----------------------------------------
  // Pixel window
  // ----------------------------------------
  // Pixel index within the current input line
  always_ff @(posedge clk) begin
    if (reset || line_start) begin
      pix_r <= irw_pkg::RST_CNT;
    end else if (pix_valid) begin
      pix_r <= pix_r + 13'h0001;
    end
  end

  // Resized index past the input start, output index past the skip
  assign ridx = pix_r - {1'b0, i_pixel_r}; // R6
  assign oidx = ridx - {1'b0, o_skip_r}; // R10
  // Busy gates output so a disable stops pixels at the next edge; a window
  // line still emits only inside the start, skip and width limits
  assign emit = busy && line_on_r && pix_valid && (pix_r >= {1'b0, i_pixel_r}) // R1
    && (ridx >= {1'b0, o_skip_r}) && (oidx < plus1(o_width_r)); // R10 R12

  // Output pixel stage
  always_ff @(posedge clk) begin
    if (reset) begin
      out_valid <= 1'b0;
      out_data <= 16'h0000;
      out_line_start <= 1'b0;
    end else begin
      out_valid <= emit;
      out_line_start <= emit && (oidx == 13'h0000);
      if (emit) begin
        out_data <= pix_data;
      end
    end
  end

  // Frame end pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      frame_done <= 1'b0;
    end else begin
      frame_done <= end_frame;
    end
  end

endmodule : irw_resizer_window

// ---- inc/irw_pkg.sv ----
// Package holding register map, field positions and reset values of the resizer window block
package irw_pkg;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFF_ENABLE = 8'h00;
  localparam logic [7:0] OFF_SINGLE = 8'h04;
  localparam logic [7:0] OFF_SEQ = 8'h08;
  localparam logic [7:0] OFF_I_LINE = 8'h0c;
  localparam logic [7:0] OFF_I_COUNT = 8'h10;
  localparam logic [7:0] OFF_I_PIXEL = 8'h14;
  localparam logic [7:0] OFF_O_COUNT = 8'h18;
  localparam logic [7:0] OFF_O_SKIP = 8'h1c;
  localparam logic [7:0] OFF_O_WIDTH = 8'h20;
  localparam logic [7:0] OFF_V_PHASE = 8'h24;
  localparam logic [7:0] OFF_LINES_DONE = 8'h28;
  localparam logic [7:0] OFF_STATUS = 8'h2c;

  // ----------------------------------------
  // Field positions and widths
  // ----------------------------------------
  localparam int ENABLE_BIT = 0;
  localparam int SINGLE_BIT = 0;
  localparam int TERM_BIT = 1;
  localparam int FLD_W = 12;
  localparam int PHASE_W = 14;
  localparam int CNT_W = 13;

  // ----------------------------------------
  // Values after reset
  // ----------------------------------------
  localparam logic RST_ENABLE = 1'b0;
  localparam logic RST_SINGLE = 1'b0;
  localparam logic RST_TERM = 1'b0;
  localparam logic [11:0] RST_FLD = 12'h000;
  localparam logic [11:0] RST_ODD_FLD = 12'h001;
  localparam logic [13:0] RST_PHASE = 14'h0000;
  localparam logic [12:0] RST_CNT = 13'h0000;

  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_WAIT = 3'b010,
    ST_RUN = 3'b100
  } irw_state_t;

endpackage : irw_pkg

// ---- test/irw_resizer_window_props.sv ----
// Port checker for the resizer window block, bound into the design
`timescale 1ns/1ps
module irw_resizer_window_props (
  input wire logic clk, // Clock
  input wire logic reset, // Synchronous reset
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_ack_o, // Bus acknowledge
  input wire logic pix_valid, // Input pixel strobe
  input wire logic out_valid, // Output pixel strobe
  input wire logic out_line_start, // First output pixel of a line
  input wire logic frame_done, // Frame end pulse
  input wire logic [13:0] phase_start, // Loaded vertical phase
  input wire logic busy // Frame running
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // ----------------------------------------
  // Register bus handshake
  // ----------------------------------------
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_after_req: assert property (s_req |=> s_ack)
    else $error("request not acknowledged once");
  a_ack_no_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("acknowledge without request");
  // ----------------------------------------
  // Pixel path and frame sequencing
  // ----------------------------------------
  a_out_from_pixel: assert property (out_valid |-> $past(pix_valid))
    else $error("output pixel without input pixel");
  a_idle_no_out: assert property (!busy |=> !out_valid)
    else $error("output pixel outside a frame");
  a_first_has_valid: assert property (out_line_start |-> out_valid)
    else $error("line start without pixel");
  a_done_pulse: assert property (frame_done |=> !frame_done)
    else $error("frame end longer than one cycle");
  a_done_after_run: assert property (frame_done |-> $past(busy) || $past(busy, 2))
    else $error("frame end without a running frame");
  a_phase_hold: assert property (busy && $past(busy) |-> $stable(phase_start))
    else $error("phase changed inside a frame");
endmodule : irw_resizer_window_props

bind irw_resizer_window irw_resizer_window_props u_props (.clk(clk), .reset(reset),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pix_valid(pix_valid),
  .out_valid(out_valid), .out_line_start(out_line_start), .frame_done(frame_done),
  .phase_start(phase_start), .busy(busy));

// ---- test/irw_pixel_source.sv ----
// Upstream image pipe model sending framed pixel lines
`timescale 1ns/1ps
module irw_pixel_source (
  input wire logic clk, // Pipeline clock
  output logic frame_start, // Vertical origin pulse
  output logic line_start, // Horizontal origin pulse
  output logic pix_valid, // Pixel strobe
  output logic [15:0] pix_data // Pixel value
);
  // Quiet lines at time zero
  initial begin
    frame_start = 1'h0;
    line_start = 1'h0;
    pix_valid = 1'h0;
    pix_data = 16'h0000;
  end
  // One frame of nl lines, np pixels each; idle data is inverted so it never looks valid
  task automatic send(input int nl, input int np);
    @(posedge clk);
    frame_start <= 1'h1;
    @(posedge clk);
    frame_start <= 1'h0;
    for (int n = 0; n < nl; n++) begin
      @(posedge clk);
      line_start <= 1'h1;
      pix_data <= ~pix_data;
      @(posedge clk);
      line_start <= 1'h0;
      for (int k = 0; k < np; k++) begin
        pix_valid <= 1'h1;
        pix_data <= {n[7:0], k[7:0]};
        @(posedge clk);
      end
      pix_valid <= 1'h0;
      pix_data <= ~pix_data;
    end
  endtask : send
endmodule : irw_pixel_source

// ---- test/irw_resizer_window_bench.sv ----
// Self-checking bench for the resizer window block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("mismatch %s expected %0h seen %0h", nm, e, g); end end
module irw_resizer_window_bench;
  localparam logic [7:0] OFFS [9] = '{irw_pkg::OFF_ENABLE, irw_pkg::OFF_SINGLE,
    irw_pkg::OFF_I_LINE, irw_pkg::OFF_I_COUNT, irw_pkg::OFF_I_PIXEL, irw_pkg::OFF_O_COUNT,
    irw_pkg::OFF_O_SKIP, irw_pkg::OFF_O_WIDTH, irw_pkg::OFF_V_PHASE};
  localparam logic [13:0] ONES [9] = '{14'h1, 14'h1, 14'hfff, 14'hfff, 14'hffe, 14'hfff,
    14'hffe, 14'hfff, 14'h3fff};
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, frame_start, line_start, pix_valid;
  logic out_valid, out_line_start, frame_done, busy;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0, rdat, rd;
  logic [15:0] pix_data, out_data;
  logic [13:0] phase_start;
  logic [16:0] got[$], exp[$];
  int fails = 0, num_checks = 0, seed = 1686, cycles = 0, ndone = 0;
  always #2.5 clk = ~clk;
  irw_resizer_window u_dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .frame_start(frame_start), .line_start(line_start),
    .pix_valid(pix_valid), .pix_data(pix_data), .out_valid(out_valid), .out_data(out_data),
    .out_line_start(out_line_start), .frame_done(frame_done), .phase_start(phase_start),
    .busy(busy));
  irw_pixel_source u_src (.clk(clk), .frame_start(frame_start), .line_start(line_start),
    .pix_valid(pix_valid), .pix_data(pix_data));
  // Collect output pixels and frame ends; cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (out_valid === 1'h1) got.push_back({out_line_start, out_data});
    if (frame_done === 1'h1) ndone++;
    if (cycles == 20000) begin
      fails++;
      summarize();
    end
  end
  // Classic single bus cycle, held until acknowledge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'h1;
    stb <= 1'h1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hf;
    do @(posedge clk); while (ack !== 1'h1);
    rd = rdat;
    cyc <= 1'h0;
    stb <= 1'h0;
    we <= 1'h0;
  endtask : wb
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0);
    `CHK(nm, e, rd)
  endtask : chk_rd
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int fl, fp, sk, w, ic, oc, vp, tgt, act, np, nl, term, one, en, r;
    int v[9];
    repeat (10) @(posedge clk);
    reset <= 1'h0;
    for (int a = 0; a < 13; a++) chk_rd("reset", 8'(a * 4), (a == 6 || a == 8) ? 1 : 0);
    for (int i = 0; i < 9; i++) begin
      wb(1'h1, OFFS[i], 32'hffffffff);
      chk_rd("ones", OFFS[i], {18'h0, ONES[i]});
      wb(1'h1, OFFS[i], 32'h0);
      chk_rd("zeros", OFFS[i], (i == 5 || i == 7) ? 32'h1 : 32'h0);
    end
    wb(1'h1, 8'h30, 32'hffffffff);
    chk_rd("unmapped", 8'h30, 32'h0);
    for (int i = 0; i < 6; i++) begin
      term = i % 2;
      one = (i / 2) % 2;
      en = (i < 5);
      fl = $random(seed) & 3;
      fp = ($random(seed) & 3) * 2;
      sk = ($random(seed) & 3) * 2;
      w = ($random(seed) & 3) * 2 + 1;
      ic = $random(seed) & 3;
      oc = ($random(seed) & 1) * 2 + 1;
      // Odd passes stand for split frames, the only use that may carry a phase
      vp = (i % 2 == 1) ? ($random(seed) & 16'h1fff) : 0;
      tgt = term ? ic + 1 : oc + 1;
      nl = fl + tgt + 1;
      np = fp + sk + w + 3;
      v = '{en, one, fl, ic, fp, oc, sk, w, vp};
      wb(1'h1, irw_pkg::OFF_SEQ, 32'(term) << 1);
      for (int j = 8; j >= 0; j--) wb(1'h1, OFFS[j], 32'(v[j]));
      exp.delete();
      got.delete();
      ndone = 0;
      act = 0;
      // Reference window: lines from fl up to the target, pixels past start and skip
      for (int n = 0; n < nl; n++) begin
        if (n >= fl && act < tgt) begin
          act++;
          for (int k = 0; k < np; k++) begin
            r = k - fp - sk;
            if (k >= fp && r >= 0 && r <= w) exp.push_back({r == 0, n[7:0], k[7:0]});
          end
        end
      end
      if (en == 0) exp.delete();
      u_src.send(nl, np);
      repeat (4) @(posedge clk);
      `CHK("pixel count", exp.size(), got.size())
      foreach (exp[k]) if (k < got.size()) `CHK("pixel", exp[k], got[k])
      `CHK("frame ends", en, ndone)
      `CHK("busy", 1'h0, busy)
      if (en != 0) begin
        `CHK("phase", 14'(vp), phase_start)
        chk_rd("lines", irw_pkg::OFF_LINES_DONE, 32'(tgt));
        chk_rd("enable", irw_pkg::OFF_ENABLE, 32'(1 - one));
      end
      wb(1'h1, irw_pkg::OFF_ENABLE, 32'h0);
    end
    summarize();
  end
endmodule : irw_resizer_window_bench
